// file: rtl/lsc_pkg.sv
// Shared constants and types for the four-slice logic cluster.
// Assumes a single system clock; every configuration value arrives as a plain port.
package lsc_pkg;
    localparam int NUM_SLICES     = 4;
    localparam int NUM_RAM_SLICES = 3;
    localparam int ROUTE_IN_W     = 15;
    localparam int ROUTE_OUT_W    = 6;
    localparam int TABLE_DEPTH    = 16;
    localparam int TABLE_AW       = 4;
    localparam int RAM_ADDR_SLICE = 2;
    localparam int WORD_W         = 4;
    // Routing input positions within one slice.
    localparam int IN_T0_LSB = 0;
    localparam int IN_T1_LSB = 4;
    localparam int IN_M0     = 8;
    localparam int IN_M1     = 9;
    localparam int IN_CE     = 10;
    localparam int IN_LSR    = 11;
    localparam int IN_DYN    = 12;
    localparam int IN_LOAD   = 13;
    localparam int IN_WE     = 14;
    // Routing output positions within one slice; the carry output is separate.
    localparam int OUT_F0   = 0;
    localparam int OUT_F1   = 1;
    localparam int OUT_Q0   = 2;
    localparam int OUT_Q1   = 3;
    localparam int OUT_OFX0 = 4;
    localparam int OUT_OFX1 = 5;
    localparam logic [ROUTE_OUT_W-1:0] ROUTE_OUT_RST = 6'h00;
    localparam logic [WORD_W-1:0]      WORD_RST      = 4'h0;

    typedef enum logic [3:0] {
        LSC_MODE_LOGIC  = 4'b0001,
        LSC_MODE_RIPPLE = 4'b0010,
        LSC_MODE_RAM    = 4'b0100,
        LSC_MODE_ROM    = 4'b1000
    } lsc_mode_type;

    typedef enum logic [9:0] {
        LSC_OP_ADD    = 10'b0000000001,
        LSC_OP_SUB    = 10'b0000000010,
        LSC_OP_ADDSUB = 10'b0000000100,
        LSC_OP_UP     = 10'b0000001000,
        LSC_OP_DOWN   = 10'b0000010000,
        LSC_OP_UPDOWN = 10'b0000100000,
        LSC_OP_GE     = 10'b0001000000,
        LSC_OP_NE     = 10'b0010000000,
        LSC_OP_LE     = 10'b0100000000,
        LSC_OP_MULT   = 10'b1000000000
    } lsc_op_type;
endpackage

// file: rtl/lsc_slice.sv
// One slice: two sixteen-entry tables, two storage bits, ripple arithmetic.
// Assumes the cluster hands it a sampled clock line, the memory address and write control.
`timescale 1ns/1ps
`default_nettype none
module lsc_slice #(
    parameter bit RAM_OK = 1'b1
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Configuration
    input  wire logic                          cfg_load,
    input  var  lsc_pkg::lsc_mode_type         mode,
    input  var  lsc_pkg::lsc_op_type           rip_op,
    input  wire logic [lsc_pkg::TABLE_DEPTH-1:0] table0_init,
    input  wire logic [lsc_pkg::TABLE_DEPTH-1:0] table1_init,
    input  wire logic                          clk_pos,
    input  wire logic                          clk_level,
    input  wire logic                          lsr_async,
    input  wire logic                          lsr_value,
    input  wire logic                          reg_from_m,
    // Cluster clock line, sampled now and one cycle earlier
    input  wire logic                          clk_now,
    input  wire logic                          clk_prev,
    // Routing and carry
    input  wire logic [lsc_pkg::ROUTE_IN_W-1:0] route_in,
    input  wire logic                          carry_in,
    // Distributed memory control from the cluster
    input  wire logic [lsc_pkg::TABLE_AW-1:0]  ram_addr,
    input  wire logic                          ram_we,
    input  wire logic [1:0]                    ram_wdata,
    // Results
    output logic                               f0,
    output logic                               f1,
    output logic [1:0]                         q,
    output logic                               five,
    output logic                               gen,
    output logic                               prop,
    output logic                               carry_out,
    output logic                               clk_event
);
    import lsc_pkg::*;

    logic [TABLE_DEPTH-1:0] tbl0, tbl1, next_tbl0, next_tbl1;
    logic [1:0]             next_q, a, b, b_eff, m;
    logic [TABLE_AW-1:0]    idx0, idx1;
    logic [2:0]             t;
    logic                   ram_mode, lt, eq, gt;

    function automatic logic [2:0] add2(input logic [1:0] x, input logic [1:0] y, input logic c);
        add2 = {1'b0, x} + {1'b0, y} + {2'b00, c};
    endfunction

    assign a        = {route_in[IN_T1_LSB], route_in[IN_T0_LSB]};
    assign b        = {route_in[IN_T1_LSB+1], route_in[IN_T0_LSB+1]};
    assign m        = {route_in[IN_M1], route_in[IN_M0]};
    assign ram_mode = RAM_OK && (mode == LSC_MODE_RAM);
    assign idx0     = ram_mode ? ram_addr : route_in[IN_T0_LSB +: TABLE_AW];
    assign idx1     = ram_mode ? ram_addr : route_in[IN_T1_LSB +: TABLE_AW];
    // Level mode is transparent while the line sits at the active level.
    assign clk_event = clk_level ? (clk_now == clk_pos) : (clk_now == clk_pos && clk_prev != clk_pos);
    assign lt = a < b;
    assign eq = a == b;
    assign gt = a > b;
    assign b_eff = (rip_op == LSC_OP_SUB || (rip_op == LSC_OP_ADDSUB && route_in[IN_DYN])) ? ~b : b;

    always_comb begin
        next_tbl0 = tbl0;
        next_tbl1 = tbl1;
        if (cfg_load) begin
            next_tbl0 = table0_init;
            next_tbl1 = table1_init;
        end else if (ram_mode && ram_we && clk_event) begin
            next_tbl0[ram_addr] = ram_wdata[0];
            next_tbl1[ram_addr] = ram_wdata[1];
        end
    end

    always_comb begin
        unique case (rip_op)
            LSC_OP_ADD, LSC_OP_SUB, LSC_OP_ADDSUB: t = add2(a, b_eff, carry_in);
            LSC_OP_UP:     t = add2(q, 2'b00, carry_in);
            LSC_OP_DOWN:   t = {carry_in && q == 2'b00, q - {1'b0, carry_in}};
            LSC_OP_UPDOWN: t = route_in[IN_DYN] ? {carry_in && q == 2'b00, q - {1'b0, carry_in}}
                                                : add2(q, 2'b00, carry_in);
            LSC_OP_GE:     t = {gt | (eq & carry_in), 1'b0, gt | (eq & carry_in)};
            LSC_OP_NE:     t = {~eq | carry_in, 1'b0, ~eq | carry_in};
            LSC_OP_LE:     t = {lt | (eq & carry_in), 1'b0, lt | (eq & carry_in)};
            LSC_OP_MULT:   t = add2(a, b & {2{route_in[IN_M0]}}, carry_in);
            default:       t = 3'h0;
        endcase
    end

    always_comb begin
        if (mode == LSC_MODE_RIPPLE) begin
            f0        = t[0];
            f1        = t[1];
            carry_out = t[2];
        end else begin
            f0        = tbl0[idx0];
            f1        = tbl1[idx1];
            carry_out = carry_in;
        end
        five = route_in[IN_M0] ? f1 : f0;
        gen  = add2(a, b_eff, 1'b0) >= 3'h4;
        prop = &(a ^ b_eff);
    end

    always_comb begin
        next_q = q;
        if (route_in[IN_LSR] && (lsr_async || clk_event)) begin
            next_q = {2{lsr_value}};
        end else if (clk_event && route_in[IN_CE]) begin
            if (reg_from_m || (mode == LSC_MODE_RIPPLE && route_in[IN_LOAD])) begin
                next_q = m;
            end else begin
                next_q = {f1, f0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tbl0 <= table0_init;
            tbl1 <= table1_init;
            q    <= 2'h0;
        end else begin
            tbl0 <= next_tbl0;
            tbl1 <= next_tbl1;
            q    <= next_q;
        end
    end
endmodule
`default_nettype wire

// file: rtl/lsc_cluster.sv
// Four-slice logic cluster: clock select, wide-function muxes, memory combining, registered outputs.
// Assumes routing inputs and clock lines are synchronous to sys_clk and already settled.
`timescale 1ns/1ps
`default_nettype none
module lsc_cluster #(
    parameter int NUM_SLICES = lsc_pkg::NUM_SLICES
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    // Cluster control
    input  wire logic [1:0]                      clk_line,
    input  wire logic                            clk_sel,
    input  wire logic                            chip_sel,
    input  wire logic                            cfg_load,
    // Per-slice configuration
    input  var  lsc_pkg::lsc_mode_type           slice_mode [NUM_SLICES],
    input  var  lsc_pkg::lsc_op_type             slice_op [NUM_SLICES],
    input  wire logic [lsc_pkg::TABLE_DEPTH-1:0] table0_init [NUM_SLICES],
    input  wire logic [lsc_pkg::TABLE_DEPTH-1:0] table1_init [NUM_SLICES],
    input  wire logic [NUM_SLICES-1:0]           clk_pos,
    input  wire logic [NUM_SLICES-1:0]           clk_level,
    input  wire logic [NUM_SLICES-1:0]           lsr_async,
    input  wire logic [NUM_SLICES-1:0]           lsr_value,
    input  wire logic [NUM_SLICES-1:0]           reg_from_m,
    input  wire logic [NUM_SLICES-1:0]           fast_carry,
    // Routing and carry chain
    input  wire logic [lsc_pkg::ROUTE_IN_W-1:0]  slice_in [NUM_SLICES],
    input  wire logic                            carry_in,
    input  wire logic                            ext_seven_in,
    // Results
    output logic [lsc_pkg::ROUTE_OUT_W-1:0]      slice_out [NUM_SLICES],
    output logic                                 carry_out,
    output logic [lsc_pkg::WORD_W-1:0]           mem_rdata
);
    import lsc_pkg::*;

    logic                   clk_now, clk_prev;
    logic [NUM_SLICES:0]    carry;
    logic [NUM_SLICES-1:0]  f0, f1, five, gen, prop, evt;
    logic [1:0]             q [NUM_SLICES];
    logic [TABLE_AW-1:0]    ram_addr;
    logic                   ram_we;
    logic                   six_lo, six_hi, seven, eight;
    logic [NUM_SLICES-1:0]  wide;
    logic [ROUTE_OUT_W-1:0] next_slice_out [NUM_SLICES];
    logic                   next_carry_out;
    logic [WORD_W-1:0]      next_mem_rdata;

    // The selected line is compared with its own previous sample to find edges.
    assign clk_now  = clk_line[clk_sel];
    assign carry[0] = carry_in;
    // Slice two lends its table inputs as the shared address and its spare input as write enable.
    assign ram_addr = slice_in[RAM_ADDR_SLICE][IN_T0_LSB +: TABLE_AW];
    assign ram_we   = slice_in[RAM_ADDR_SLICE][IN_WE] & chip_sel;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_now;
        end
    end

    for (genvar i = 0; i < NUM_SLICES; i++) begin : g_slice
        lsc_slice #(
            .RAM_OK (i < NUM_RAM_SLICES)
        ) u_slice (
            .sys_clk     (sys_clk),
            .rst         (rst),
            .cfg_load    (cfg_load),
            .mode        (slice_mode[i]),
            .rip_op      (slice_op[i]),
            .table0_init (table0_init[i]),
            .table1_init (table1_init[i]),
            .clk_pos     (clk_pos[i]),
            .clk_level   (clk_level[i]),
            .lsr_async   (lsr_async[i]),
            .lsr_value   (lsr_value[i]),
            .reg_from_m  (reg_from_m[i]),
            .clk_now     (clk_now),
            .clk_prev    (clk_prev),
            .route_in    (slice_in[i]),
            .carry_in    (carry[i]),
            .ram_addr    (ram_addr),
            .ram_we      (ram_we),
            .ram_wdata   ((i < 2) ? {slice_in[i][IN_M1], slice_in[i][IN_M0]} : 2'b00),
            .f0          (f0[i]),
            .f1          (f1[i]),
            .q           (q[i]),
            .five        (five[i]),
            .gen         (gen[i]),
            .prop        (prop[i]),
            .carry_out   (carry[i+1]),
            .clk_event   (evt[i])
        );
    end

    // Wide functions: pairs of five-input results make six, pairs of six make seven,
    // and the eighth input level needs a seven from the neighbouring cluster.
    always_comb begin
        six_lo = slice_in[0][IN_M1] ? five[1] : five[0];
        six_hi = slice_in[2][IN_M1] ? five[3] : five[2];
        seven  = slice_in[1][IN_M1] ? six_hi : six_lo;
        eight  = slice_in[3][IN_M1] ? ext_seven_in : seven;
        wide   = {eight, six_hi, seven, six_lo};
    end

    always_comb begin
        for (int i = 0; i < NUM_SLICES; i++) begin
            next_slice_out[i][OUT_F0]   = f0[i];
            next_slice_out[i][OUT_F1]   = f1[i];
            next_slice_out[i][OUT_Q0]   = q[i][0];
            next_slice_out[i][OUT_Q1]   = q[i][1];
            next_slice_out[i][OUT_OFX0] = fast_carry[i] ? gen[i] : five[i];
            next_slice_out[i][OUT_OFX1] = fast_carry[i] ? prop[i] : wide[i];
        end
        next_carry_out = carry[NUM_SLICES];
        // Four tables of slices zero and one read out as one word.
        next_mem_rdata = {f1[1], f0[1], f1[0], f0[0]};
    end

    // Registering the outputs costs a cycle of latency but keeps routing timing predictable.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_SLICES; i++) begin
                slice_out[i] <= ROUTE_OUT_RST;
            end
            carry_out <= 1'b0;
            mem_rdata <= WORD_RST;
        end else begin
            for (int i = 0; i < NUM_SLICES; i++) begin
                slice_out[i] <= next_slice_out[i];
            end
            carry_out <= next_carry_out;
            mem_rdata <= next_mem_rdata;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_table_after_reset: assert property (
        $past(rst) && slice_mode[0] == LSC_MODE_LOGIC && !cfg_load
        |-> f0[0] == table0_init[0][slice_in[0][IN_T0_LSB +: TABLE_AW]])
        else $error("table read after reset differs from initial contents");

    chk_five_select: assert property (
        slice_mode[1] == LSC_MODE_LOGIC && !fast_carry[1]
        |=> slice_out[1][OUT_OFX0] == ($past(slice_in[1][IN_M0]) ? $past(f1[1]) : $past(f0[1])))
        else $error("five-input output does not follow its select");

    chk_ripple_add: assert property (
        slice_mode[0] == LSC_MODE_RIPPLE && slice_op[0] == LSC_OP_ADD
        |-> {carry[1], f1[0], f0[0]} == 3'({slice_in[0][IN_T1_LSB], slice_in[0][IN_T0_LSB]})
            + 3'({slice_in[0][IN_T1_LSB+1], slice_in[0][IN_T0_LSB+1]}) + 3'(carry_in))
        else $error("two-bit addition result wrong");

    chk_counter_step: assert property (
        slice_mode[1] == LSC_MODE_RIPPLE && !slice_in[1][IN_DYN] && carry[1] && evt[1]
        && (slice_op[1] == LSC_OP_UP || slice_op[1] == LSC_OP_UPDOWN)
        && slice_in[1][IN_CE] && !slice_in[1][IN_LSR] && !slice_in[1][IN_LOAD] && !reg_from_m[1]
        |=> q[1] == 2'($past(q[1]) + 2'h1) ##1 slice_out[1][OUT_Q1:OUT_Q0] == $past(q[1]))
        else $error("up counter stage did not step by one");

    chk_lsr_async: assert property (
        slice_in[2][IN_LSR] && lsr_async[2]
        |=> q[2] == {2{$past(lsr_value[2])}} ##1 slice_out[2][OUT_Q0] == $past(q[2][0]))
        else $error("asynchronous set or reset not applied");

    chk_hold_no_event: assert property (
        !evt[1] && !slice_in[1][IN_LSR] |=> $stable(q[1]))
        else $error("slice register changed without a clock event");

    chk_ram_write_read: assert property (
        slice_mode[0] == LSC_MODE_RAM && ram_we && evt[0] && !cfg_load
        ##1 $stable(ram_addr) && slice_mode[0] == LSC_MODE_RAM
        |-> f0[0] == $past(slice_in[0][IN_M0]) ##1 mem_rdata[0] == $past(f0[0]))
        else $error("distributed memory read does not return written bit");

    chk_slice3_no_ram: assert property (
        slice_mode[3] == LSC_MODE_RAM && !cfg_load
        |-> f0[3] == table0_init[3][slice_in[3][IN_T0_LSB +: TABLE_AW]])
        else $error("slice three acted as writable memory");

    chk_eight_wide: assert property (
        !fast_carry[3] |=> slice_out[3][OUT_OFX1]
            == ($past(slice_in[3][IN_M1]) ? $past(ext_seven_in) : $past(seven)))
        else $error("eight-input select wrong");

    chk_gen_prop: assert property (
        fast_carry[0] |=> slice_out[0][OUT_OFX0] == $past(gen[0]) && slice_out[0][OUT_OFX1] == $past(prop[0]))
        else $error("carry generate or propagate not routed");

    cov_ram_write: cover property (slice_mode[0] == LSC_MODE_RAM && ram_we && evt[0]);
    cov_count_carry: cover property (slice_mode[0] == LSC_MODE_RIPPLE && carry[1] && evt[0]);
    cov_eight_ext: cover property (slice_in[3][IN_M1] && ext_seven_in);
    cov_level_clock: cover property (clk_level[1] && evt[1] ##1 evt[1]);
endmodule
`default_nettype wire

// file: sim/lsc_fabric.sv
// Model of the neighbouring cluster and routing that feed the cluster's chain inputs.
// Assumes the bench sets the requested levels just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module lsc_fabric (
    // Requests from the bench
    input  wire logic carry_req,
    input  wire logic seven_req,
    // Toward the cluster
    output logic      carry_in,
    output logic      ext_seven_in
);
    // The neighbour's carry is a plain level; it has no clock of its own here.
    assign carry_in     = carry_req;
    assign ext_seven_in = seven_req;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the four-slice logic cluster.
// Assumes the cluster registers every output one cycle after it samples its inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lsc_pkg::*;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic [1:0]        clk_line = 2'b00;
    logic              chip_sel = 1'b0;
    logic              clk_sel = 1'b0;
    logic              cfg_load = 1'b0;
    logic [3:0]        lsr_async = 4'h0;
    logic [3:0]        fast_carry = 4'h0;
    logic              seven_req = 1'b0;
    lsc_mode_type      slice_mode [4] = '{default: LSC_MODE_LOGIC};
    lsc_op_type        slice_op [4] = '{default: LSC_OP_ADD};
    logic [15:0]       table0_init [4] = '{16'h9c35, 16'h5a0f, 16'he721, 16'h3bd8};
    logic [15:0]       table1_init [4] = '{16'h46e9, 16'hc3a7, 16'h18f2, 16'hb05d};
    logic [3:0]        clk_pos = 4'hf;
    logic [3:0]        clk_level = 4'h0;
    logic [3:0]        lsr_value = 4'h0;
    logic [3:0]        reg_from_m = 4'h0;
    logic [14:0]       slice_in [4] = '{default: 15'h0000};
    logic              carry_req = 1'b0;
    logic              carry_in;
    logic              ext_seven_in;
    logic [5:0]        slice_out [4];
    logic              carry_out;
    logic [3:0]        mem_rdata;
    int                num_errors = 0;
    int                total_checks = 0;
    int                cycles = 0;

    lsc_fabric lsc_fabric_i (.carry_req(carry_req), .seven_req(seven_req), .carry_in(carry_in),
                             .ext_seven_in(ext_seven_in));
    lsc_cluster lsc_cluster_i (.sys_clk(sys_clk), .rst(rst), .clk_line(clk_line), .clk_sel(clk_sel),
        .chip_sel(chip_sel), .cfg_load(cfg_load), .slice_mode(slice_mode), .slice_op(slice_op),
        .table0_init(table0_init), .table1_init(table1_init), .clk_pos(clk_pos), .clk_level(clk_level),
        .lsr_async(lsr_async), .lsr_value(lsr_value), .reg_from_m(reg_from_m), .fast_carry(fast_carry),
        .slice_in(slice_in), .carry_in(carry_in), .ext_seven_in(ext_seven_in), .slice_out(slice_out),
        .carry_out(carry_out), .mem_rdata(mem_rdata));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Roughly 450 cycles are needed; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One pulse of the cluster clock line: high on two samples, then three edges for the registers.
    task automatic pulse(input logic ln = 1'b0);
        @(posedge sys_clk);
        clk_line <= ln ? 2'b10 : 2'b01;
        repeat (2) @(posedge sys_clk);
        clk_line <= 2'b00;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic t_logic();
        for (int n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            for (int i = 0; i < 4; i++) slice_in[i] <= 15'({n[3:0], 4'(15 - n)});
            @(posedge sys_clk);
            @(negedge sys_clk);
            for (int i = 0; i < 4; i++)
                chk(16'(slice_out[i][1:0]), 16'({table1_init[i][n], table0_init[i][15-n]}));
        end
    endtask

    task automatic t_ripple();
        lsc_op_type ops [5];
        logic [1:0] a;
        logic [1:0] b;
        logic       ci;
        logic       dyn;
        logic [2:0] e;
        ops = '{LSC_OP_ADD, LSC_OP_SUB, LSC_OP_ADDSUB, LSC_OP_GE, LSC_OP_NE};
        for (int k = 0; k < 5; k++) begin
            for (int v = 0; v < 32; v++) begin
                a = v[3:2];
                b = v[1:0];
                ci = v[4];
                dyn = v[2] ^ v[0];
                @(posedge sys_clk);
                slice_mode[0] <= LSC_MODE_RIPPLE;
                slice_op[0] <= ops[k];
                carry_req <= ci;
                slice_in[0] <= {2'b00, dyn, 6'h00, b[1], a[1], 2'b00, b[0], a[0]};
                case (ops[k])
                    LSC_OP_ADD: e = {1'b0, a} + {1'b0, b} + {2'b00, ci};
                    LSC_OP_SUB: e = {1'b0, a} + {1'b0, ~b} + {2'b00, ci};
                    LSC_OP_ADDSUB: e = {1'b0, a} + {1'b0, dyn ? ~b : b} + {2'b00, ci};
                    LSC_OP_GE: e = {2'b00, (a > b) || (a == b && ci)};
                    default: e = {2'b00, (a != b) || ci};
                endcase
                @(posedge sys_clk);
                @(negedge sys_clk);
                if (k < 3) chk(16'({carry_out, slice_out[0][1:0]}), 16'(e));
                else chk(16'(slice_out[0][0]), 16'(e[0]));
            end
        end
        @(posedge sys_clk);
        slice_mode[0] <= LSC_MODE_LOGIC;
        carry_req <= 1'b1;
    endtask

    task automatic t_count();
        @(posedge sys_clk);
        slice_mode[1] <= LSC_MODE_RIPPLE;
        slice_op[1] <= LSC_OP_UPDOWN;
        slice_in[1] <= 15'h0c00;
        lsr_value[1] <= 1'b1;
        pulse();
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0003);
        @(posedge sys_clk);
        slice_in[1] <= 15'h0400;
        repeat (3) pulse();
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0002);
        @(posedge sys_clk);
        clk_level[1] <= 1'b1;
        pulse();
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0000);
        @(posedge sys_clk);
        clk_level[1] <= 1'b0;
        slice_in[1] <= 15'h1400;
        pulse();
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0003);
        @(posedge sys_clk);
        slice_in[1] <= 15'h2600;
        pulse();
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0002);
    endtask

    task automatic t_ctrl();
        @(posedge sys_clk);
        clk_sel <= 1'b1;
        slice_in[1] <= 15'h0400;
        pulse(1'b0);
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0002);
        pulse(1'b1);
        @(negedge sys_clk);
        chk(16'(slice_out[1][3:2]), 16'h0003);
        @(posedge sys_clk);
        clk_sel <= 1'b0;
        slice_in[1] <= 15'h0000;
        lsr_async[2] <= 1'b1;
        lsr_value[2] <= 1'b1;
        slice_in[2] <= 15'h0800;
        slice_op[0] <= LSC_OP_ADD;
        fast_carry[0] <= 1'b1;
        slice_in[0] <= 15'h0013;
        slice_in[3] <= 15'h0203;
        seven_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(slice_out[2][3:2]), 16'h0003);
        chk(16'(slice_out[0][5:4]), 16'h0001);
        chk(16'(slice_out[3][5:4]), 16'({1'b1, table0_init[3][3]}));
        @(posedge sys_clk);
        lsr_async[2] <= 1'b0;
        slice_in[2] <= 15'h0000;
        fast_carry[0] <= 1'b0;
        seven_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(slice_out[3][5]), 16'h0000);
    endtask

    task automatic t_ram();
        logic [3:0] w;
        logic [3:0] nw;
        w = {table1_init[1][5], table0_init[1][5], table1_init[0][5], table0_init[0][5]};
        nw = ~w;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) slice_mode[i] <= LSC_MODE_RAM;
        slice_in[0] <= 15'h0000;
        slice_in[1] <= 15'h0000;
        slice_in[2] <= 15'h0005;
        slice_in[3] <= 15'h0005;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(mem_rdata), 16'(w));
        @(posedge sys_clk);
        slice_in[0] <= {5'h00, nw[1], nw[0], 8'h00};
        slice_in[1] <= {5'h00, nw[3], nw[2], 8'h00};
        slice_in[2] <= 15'h4005;
        slice_in[3] <= 15'h4005;
        pulse();
        @(negedge sys_clk);
        chk(16'(mem_rdata), 16'(w));
        @(posedge sys_clk);
        chip_sel <= 1'b1;
        pulse();
        @(negedge sys_clk);
        chk(16'(mem_rdata), 16'(nw));
        chk(16'(slice_out[3][0]), 16'(table0_init[3][5]));
        @(posedge sys_clk);
        cfg_load <= 1'b1;
        @(posedge sys_clk);
        cfg_load <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(mem_rdata), 16'(w));
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        for (int i = 0; i < 4; i++) chk(16'(slice_out[i]), 16'h0000);
        chk(16'({carry_out, mem_rdata}), 16'h0000);
        t_logic();
        t_ripple();
        t_count();
        t_ctrl();
        t_ram();
        conclude();
    end
endmodule
`default_nettype wire
